// File: design/ucr_params.svh
/*
  Constants for the core clock and USB rate selector: divide ratios, rate figures,
  and accumulator sizes. Assumes a 100 MHz system clock and a crystal of 12 MHz or less.
*/
// Behaviour
// - USB lines are sampled at four times the selected USB bit rate.
// - One core state clock is derived and fed to processor and all peripherals.
// - After reset, with the PLL strap high, the core runs at 3 MHz until low-clock is cleared.
// - In low-clock mode each state spans four crystal periods.
// - Low-clock mode changes only the core clock, never the USB rates.
// - Signalling is 1.5 Mbps at low speed and 12 Mbps at full speed.
// - Low-clock writes are accepted anytime and switch either way repeatedly.
`ifndef UCR_PARAMS_SVH
`define UCR_PARAMS_SVH

// ============================================================
// Core state timing
// ============================================================
`define UCR_OSC_PER_STATE_NORMAL 3'h2
`define UCR_OSC_PER_STATE_LOW    3'h4
`define UCR_LOW_CLOCK_RESET      1'h1

// ============================================================
// USB rates, in tenths of a Mbps so that 1.5 stays exact
// ============================================================
`define UCR_SYS_CLK_MHZ          100
`define UCR_FS_BIT_RATE_X10      120
`define UCR_LS_BIT_RATE_X10      15
`define UCR_SAMPLES_PER_BIT      4
`define UCR_NCO_MOD              (`UCR_SYS_CLK_MHZ * 10)
`define UCR_FS_STEP              (`UCR_FS_BIT_RATE_X10 * `UCR_SAMPLES_PER_BIT)
`define UCR_LS_STEP              (`UCR_LS_BIT_RATE_X10 * `UCR_SAMPLES_PER_BIT)
`define UCR_NCO_W                11
`define UCR_SMP_LAST             2'h3

`endif

// File: design/ucr_pkg.sv
/*
  Types for the core clock and USB rate selector.
  Assumes ucr_params.svh is on the include path.
*/
package ucr_pkg;

  typedef enum logic [1:0] {
    UCR_NORMAL = 2'b01,
    UCR_LOW    = 2'b10
  } ucr_mode_t;

endpackage : ucr_pkg

// File: design/ucr_clock_rate.sv
/*
  Core state clock enable and USB bit and sample enables, all on clk_sys_i.
  Assumes the crystal waveform and both straps arrive asynchronously on pins, and that
  the low-clock bit write comes from the power control register logic on clk_sys_i.
*/
`include "ucr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ucr_clock_rate (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic              crystal_input_i,
  input  wire logic              pll_select_strap_i,
  input  wire logic              speed_select_strap_i,
  input  wire logic              low_clock_sel_wr_i,
  input  wire logic              low_clock_sel_d_i,
  output logic                   low_clock_sel_o,
  output var ucr_pkg::ucr_mode_t core_mode_o,
  output logic                   core_clk_en_o,
  output logic                   usb_sample_en_o,
  output logic                   usb_bit_en_o,
  output logic                   full_speed_o,
  output logic                   pll_on_o
);
  import ucr_pkg::*;

  // ============================================================
  // Pin synchronisers
  // ============================================================
  logic [2:0] xtal_sync;
  logic [2:0] pll_sync;
  logic [2:0] fs_sync;
  logic       xtal_q;
  logic       xtal_rise;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xtal_sync <= 3'h0;
      pll_sync  <= 3'h0;
      fs_sync   <= 3'h0;
    end else begin
      xtal_sync <= {xtal_sync[1:0], crystal_input_i};
      pll_sync  <= {pll_sync[1:0], pll_select_strap_i};
      fs_sync   <= {fs_sync[1:0], speed_select_strap_i};
    end
  end

  // A change is accepted only once the second and third stages agree.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xtal_q <= 1'h0;
    end else if (xtal_sync[1] == xtal_sync[2]) begin
      xtal_q <= xtal_sync[2];
    end
  end

  assign xtal_rise = (xtal_sync[1] == xtal_sync[2]) && xtal_sync[2] && !xtal_q;

  // The straps are expected to be static; they are filtered the same way anyway.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pll_on_o <= 1'h0;
    end else if (pll_sync[1] == pll_sync[2]) begin
      pll_on_o <= pll_sync[2];
    end
  end

  // Both straps are filtered first, so a joint change never shows a one-cycle full-speed glitch.
  logic fs_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fs_q <= 1'h0;
    end else if (fs_sync[1] == fs_sync[2]) begin
      fs_q <= fs_sync[2];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      full_speed_o <= 1'h0;
    end else begin
      full_speed_o <= fs_q && pll_on_o;
    end
  end

  // ============================================================
  // Low-clock control bit
  // ============================================================
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_clock_sel_o <= `UCR_LOW_CLOCK_RESET;
    end else if (low_clock_sel_wr_i) begin
      low_clock_sel_o <= low_clock_sel_d_i;
    end
  end

  // ============================================================
  // Core state divider
  // ============================================================
  logic [2:0] osc_cnt;
  logic [2:0] osc_per_state;
  logic       state_end;
  ucr_mode_t  next_mode;

  // With the PLL strap low the crystal is already halved, so low-clock adds nothing.
  assign next_mode     = (low_clock_sel_o && pll_on_o) ? UCR_LOW : UCR_NORMAL;
  assign osc_per_state = (core_mode_o == UCR_LOW) ? `UCR_OSC_PER_STATE_LOW
                                                  : `UCR_OSC_PER_STATE_NORMAL;
  assign state_end     = xtal_rise && (osc_cnt == osc_per_state - 3'h1);
  assign core_clk_en_o = state_end;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_cnt <= 3'h0;
    end else if (state_end) begin
      osc_cnt <= 3'h0;
    end else if (xtal_rise) begin
      osc_cnt <= osc_cnt + 3'h1;
    end
  end

  // Switching mid-state would clip a phase, so the new ratio waits for the boundary.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_mode_o <= UCR_LOW;
    end else if (state_end) begin
      unique case (core_mode_o)
        UCR_NORMAL: core_mode_o <= next_mode;
        UCR_LOW:    core_mode_o <= next_mode;
      endcase
    end
  end

  // ============================================================
  // USB sample and bit enables
  // ============================================================
  // A fractional accumulator keeps the average rate exact; the enables jitter by one
  // system clock, which the sampler tolerates at four samples per bit.
  logic [`UCR_NCO_W-1:0] nco_acc;
  logic [`UCR_NCO_W-1:0] nco_step;
  logic [`UCR_NCO_W-1:0] nco_sum;
  logic [1:0]            smp_cnt;

  assign nco_step = full_speed_o ? `UCR_NCO_W'(`UCR_FS_STEP)
                                 : `UCR_NCO_W'(`UCR_LS_STEP);
  assign nco_sum  = nco_acc + nco_step;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nco_acc         <= '0;
      usb_sample_en_o <= 1'h0;
    end else if (nco_sum >= `UCR_NCO_W'(`UCR_NCO_MOD)) begin
      nco_acc         <= nco_sum - `UCR_NCO_W'(`UCR_NCO_MOD);
      usb_sample_en_o <= 1'h1;
    end else begin
      nco_acc         <= nco_sum;
      usb_sample_en_o <= 1'h0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      smp_cnt <= 2'h0;
    end else if (usb_sample_en_o) begin
      smp_cnt <= smp_cnt + 2'h1;
    end
  end

  assign usb_bit_en_o = usb_sample_en_o && (smp_cnt == `UCR_SMP_LAST);

  // ============================================================
  // Checks
  // ============================================================
  logic [2:0] span;
  logic [3:0] gap;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      span <= 3'h0;
    end else if (state_end) begin
      span <= 3'h0;
    end else if (xtal_rise) begin
      span <= span + 3'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap <= 4'h0;
    end else if (usb_sample_en_o) begin
      gap <= 4'h0;
    end else if (gap != 4'hf) begin
      gap <= gap + 4'h1;
    end
  end

  // Only a gap that opened and closed at full speed is held to the full-speed window.
  logic fs_steady;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fs_steady <= 1'h0;
    end else if (!full_speed_o) begin
      fs_steady <= 1'h0;
    end else if (usb_sample_en_o) begin
      fs_steady <= 1'h1;
    end
  end

  bit_four_samples_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    usb_bit_en_o |=> (smp_cnt == 2'h0) ##0 (!usb_bit_en_o) [*7])
    else $error("bit enable not on every fourth sample");

  fs_sample_gap_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (usb_sample_en_o && fs_steady) |-> (gap >= 4'h1 && gap <= 4'h2))
    else $error("full speed sample spacing wrong");

  core_on_xtal_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    core_clk_en_o |-> xtal_rise)
    else $error("core enable off a crystal edge");

  lc_clear_only_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(low_clock_sel_o) |-> $past(low_clock_sel_wr_i && !low_clock_sel_d_i))
    else $error("low clock left without a clearing write");

  low_span_four_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (core_clk_en_o && core_mode_o == UCR_LOW) |-> (span == 3'h3))
    else $error("low clock state not four crystal periods");

  usb_indep_lc_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ($changed(core_mode_o) && $stable(full_speed_o)) |->
      $stable(nco_step) && (smp_cnt == 2'($past(smp_cnt) + $past(usb_sample_en_o))))
    else $error("USB rate disturbed by mode change");

  speed_step_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    full_speed_o |-> nco_step == `UCR_NCO_W'(`UCR_FS_STEP))
    else $error("full speed rate not selected");

  write_any_time_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    low_clock_sel_wr_i |=> low_clock_sel_o == $past(low_clock_sel_d_i))
    else $error("low clock write not taken");

  mode_at_bound_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $changed(core_mode_o) |-> $past(core_clk_en_o))
    else $error("core mode changed mid state");

endmodule : ucr_clock_rate

`default_nettype wire

// File: testbench/tb_top.sv
/*
  Self-checking bench for the core clock and USB rate selector.
  Assumes ucr_pkg is compiled first and that the design reaches the bench as ucr_clock_rate.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import ucr_pkg::*;
  logic      clk_sys_i, rst_n_i, pll_select_strap_i, speed_select_strap_i;
  logic      crystal_input_i = 1'b0;
  logic      low_clock_sel_wr_i, low_clock_sel_d_i, low_clock_sel_o;
  ucr_mode_t core_mode_o;
  logic      core_clk_en_o, usb_sample_en_o, usb_bit_en_o, full_speed_o, pll_on_o;
  logic [2:0] xtal_cnt = 3'h0;
  int        fail_count, total_checks;

  ucr_clock_rate dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .crystal_input_i(crystal_input_i), .pll_select_strap_i(pll_select_strap_i),
    .speed_select_strap_i(speed_select_strap_i), .low_clock_sel_wr_i(low_clock_sel_wr_i),
    .low_clock_sel_d_i(low_clock_sel_d_i), .low_clock_sel_o(low_clock_sel_o),
    .core_mode_o(core_mode_o), .core_clk_en_o(core_clk_en_o),
    .usb_sample_en_o(usb_sample_en_o), .usb_bit_en_o(usb_bit_en_o),
    .full_speed_o(full_speed_o), .pll_on_o(pll_on_o));

  // ============================================================
  // Clock and crystal
  // ============================================================
  // The crystal runs at eight system cycles a period, so a state spans 16 or 32 cycles.
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    xtal_cnt        <= xtal_cnt + 3'h1;
    crystal_input_i <= xtal_cnt[2];
  end

  // ============================================================
  // Shared tasks
  // ============================================================
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr_low(input logic v);
    @(posedge clk_sys_i) begin
      low_clock_sel_wr_i <= 1'b1;
      low_clock_sel_d_i  <= v;
    end
    @(posedge clk_sys_i) low_clock_sel_wr_i <= 1'b0;
    #1 chk(low_clock_sel_o, v);
  endtask : wr_low

  // Waits for a core pulse, then returns the cycle count to the next one.
  task automatic span(output int n);
    int k;
    n = 0;
    for (k = 0; k < 200 && core_clk_en_o !== 1'b1; k++) @(posedge clk_sys_i) #1;
    for (n = 1; n < 200; n++) begin
      @(posedge clk_sys_i) #1;
      if (core_clk_en_o === 1'b1) break;
    end
  endtask : span

  task automatic usb_rate(input int smp, input int bits);
    int s, b, k;
    s = 0;
    b = 0;
    for (k = 0; k < 1000; k++) begin
      @(posedge clk_sys_i) #1;
      s += (usb_sample_en_o === 1'b1);
      b += (usb_bit_en_o === 1'b1);
    end
    chk(s, smp);
    chk(b, bits);
  endtask : usb_rate

  // ============================================================
  // Scenarios
  // ============================================================
  task automatic t_reset_low;
    int n;
    chk(low_clock_sel_o, 1'b1);
    chk(core_mode_o, UCR_LOW);
    span(n);
    span(n);
    chk(n, 32);
    usb_rate(480, 120);
  endtask : t_reset_low

  // The mode may only follow the write at the cycle after a core pulse.
  task automatic t_switch(input logic v, input ucr_mode_t old_m, input ucr_mode_t new_m,
                          input int exp_span);
    int k, n;
    wr_low(v);
    for (k = 0; k < 200; k++) begin
      chk(core_mode_o, old_m);
      if (core_clk_en_o === 1'b1) break;
      @(posedge clk_sys_i) #1;
    end
    @(posedge clk_sys_i) #1 chk(core_mode_o, new_m);
    span(n);
    chk(n, exp_span);
  endtask : t_switch

  task automatic t_back_to_back;
    @(posedge clk_sys_i) begin
      low_clock_sel_wr_i <= 1'b1;
      low_clock_sel_d_i  <= 1'b1;
    end
    @(posedge clk_sys_i) low_clock_sel_d_i <= 1'b0;
    #1 chk(low_clock_sel_o, 1'b1);
    @(posedge clk_sys_i) low_clock_sel_wr_i <= 1'b0;
    #1 chk(low_clock_sel_o, 1'b0);
  endtask : t_back_to_back

  task automatic t_straps;
    int n;
    @(posedge clk_sys_i) speed_select_strap_i <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    #1 chk(full_speed_o, 1'b0);
    usb_rate(60, 15);
    wr_low(1'b1);
    @(posedge clk_sys_i) begin
      pll_select_strap_i   <= 1'b0;
      speed_select_strap_i <= 1'b1;
    end
    repeat (10) @(posedge clk_sys_i);
    #1 chk({pll_on_o, full_speed_o}, 2'h0);
    span(n);
    span(n);
    chk(n, 16);
  endtask : t_straps

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  initial begin
    fail_count = 0;
    total_checks = 0;
    pll_select_strap_i = 1'b1;
    speed_select_strap_i = 1'b1;
    low_clock_sel_wr_i = 1'b0;
    low_clock_sel_d_i = 1'b0;
    rst_n_i = 1'b0;
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    #1 t_reset_low();
    t_switch(1'b0, UCR_LOW, UCR_NORMAL, 16);
    usb_rate(480, 120);
    t_switch(1'b1, UCR_NORMAL, UCR_LOW, 32);
    t_back_to_back();
    t_straps();
    test_done();
  end

  // A hang is cut short well past the few thousand cycles the tests need.
  initial begin
    #200000;
    fail_count++;
    test_done();
  end
endmodule : tb_top

`default_nettype wire
